// [include/sesp_pkg.sv]
package sesp_pkg;

  // ============================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int GLITCH_NS = 100;
  localparam int GLITCH_CYC = (GLITCH_NS / CLK_PERIOD_NS < 1) ? 1 : GLITCH_NS / CLK_PERIOD_NS;
  localparam int NONVOLATILE_WRITE_TIME_US = 5000;
  localparam int WRITE_CYC = NONVOLATILE_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SUPPLY_TO_READY_DELAY_US = 1000;
  localparam int READY_CYC = SUPPLY_TO_READY_DELAY_US * 1000 / CLK_PERIOD_NS;

  // ============================================================
  // Widths and codes
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int TMR_W = 16;
  localparam int FILT_W = 4;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [2:0] NO_STRAP_ADDR = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    SESP_IDLE, SESP_DEV_ADDR, SESP_ACK_DEV, SESP_ADDR_HI, SESP_ACK_HI,
    SESP_ADDR_LO, SESP_ACK_LO, SESP_WR_DATA, SESP_ACK_WR, SESP_RD_DATA, SESP_RD_ACK
  } sesp_state_e;

  typedef struct packed {
    logic [PAGE_W-1:0] offset;
    logic [7:0] data;
  } sesp_wbyte_s;

  localparam int WBYTE_W = $bits(sesp_wbyte_s);

endpackage : sesp_pkg

// [rtl/sesp_port.sv]
// Contract
// R01: Master drives clock; device only receives it
// R02: Sample data on rise, change after fall
// R03: Data output is open-drain, low only
// R04: Straps must match slave address bits
// R05: Floating strap reads as low
// R06: Write inhibit high blocks all writes
// R07: Floating write inhibit reads as low
// R08: Strapless package always allows writes
// R09: Ignore glitches up to 100 ns
// R10: Master keeps clock within supported class
// R11: Ready for commands within 1 ms
// R12: Standby after supply good, reset below
// R13: Address type bits must be 1010
// R14: Strapless package answers only strap 000
// R15: Inhibit sampled before data; reject, no ack
// R16: During write cycle release line, no ack
// R17: Write cycle ends within write time
`timescale 1ns/1ns
`default_nettype none

module sesp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic full, empty, push, pop;

  always_comb begin
    empty = (wr_ptr == rd_ptr);
    full = (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]) && (wr_ptr[PW] != rd_ptr[PW]);
    in_ready_out = !full;
    out_valid_out = !empty;
    out_data_out = mem[rd_ptr[PW-1:0]];
    push = in_valid_in && !full;
    pop = out_ready_in && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage has no reset; only words between the pointers are ever read
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data_in;
    end
  end
endmodule : sesp_fifo

module sesp_port #(
  parameter int WR_CYCLES = sesp_pkg::WRITE_CYC,
  parameter int PU_CYCLES = sesp_pkg::READY_CYC
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic addr_strap_bit0_in,
  input wire logic addr_strap_bit1_in,
  input wire logic addr_strap_bit2_in,
  input wire logic write_inhibit_in,
  input wire logic strapless_pkg_in,
  output logic ready_out,
  output logic write_busy_out
);
  // ============================================================
  // Pin synchronisers
  logic [6:0] sync1, sync2;
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {strapless_pkg_in, write_inhibit_in, addr_strap_bit2_in, addr_strap_bit1_in,
                addr_strap_bit0_in, sda_in, scl_in}; // R01
      sync2 <= sync1; // R10
    end
  end

  // ============================================================
  // Glitch filters on clock and data
  logic [1:0] filt, filt_d;
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [sesp_pkg::FILT_W-1:0] cnt, next_cnt;
    logic next_lvl;
    always_comb begin
      next_cnt = '0;
      next_lvl = filt[g];
      if (sync2[g] != filt[g]) begin
        if (cnt == sesp_pkg::FILT_W'(sesp_pkg::GLITCH_CYC)) begin
          next_lvl = sync2[g]; // R09
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
    end
    // Bus idles high, so the filters start high
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        cnt <= '0;
        filt[g] <= 1'b1;
        filt_d[g] <= 1'b1;
      end else begin
        cnt <= next_cnt;
        filt[g] <= next_lvl;
        filt_d[g] <= filt[g];
      end
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [2:0] strap_eff;
  logic wp_eff, dev_match;
  assign scl_rise = filt[0] && !filt_d[0];
  assign scl_fall = !filt[0] && filt_d[0];
  assign start_cond = filt[0] && filt_d[0] && filt_d[1] && !filt[1];
  assign stop_cond = filt[0] && filt_d[0] && !filt_d[1] && filt[1];
  // Pulldowns on unused pins make a floating input read as low
  assign strap_eff = sync2[6] ? sesp_pkg::NO_STRAP_ADDR : sync2[4:2]; // R05 R14
  assign wp_eff = sync2[5] && !sync2[6]; // R07 R08

  // ============================================================
  // Power-up and write-cycle state
  logic ready, busy, next_ready, next_busy, commit_go;
  logic [sesp_pkg::TMR_W-1:0] pu_cnt, next_pu_cnt, tmr, next_tmr;
  logic [sesp_pkg::PAGE_BYTES-1:0] page_vld, next_page_vld;
  logic [7:0] page_buf [sesp_pkg::PAGE_BYTES];
  logic [7:0] mem [2**sesp_pkg::ADDR_W];
  logic mem_we, pop_valid;
  sesp_pkg::sesp_wbyte_s push_data, pop_data;
  logic push_valid, push_ready;
  logic [sesp_pkg::PAGE_W-1:0] idx;
  logic [sesp_pkg::ADDR_W-sesp_pkg::PAGE_W-1:0] page_base, next_page;

  // ============================================================
  // Bus protocol state
  sesp_pkg::sesp_state_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, rd_byte;
  logic [sesp_pkg::ADDR_W-1:0] addr, next_addr;
  logic oe, next_oe, wp_lat, next_wp, pending, next_pending;

  assign rd_byte = mem[addr];
  assign dev_match = (sh[7:4] == sesp_pkg::DEV_TYPE) && (sh[3:1] == strap_eff) && ready && !busy; // R04 R13 R16 R11
  assign push_data = '{offset: addr[sesp_pkg::PAGE_W-1:0], data: sh};

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_addr = addr;
    next_page = page_base;
    next_oe = oe;
    next_wp = wp_lat;
    next_pending = pending;
    push_valid = 1'b0;
    commit_go = 1'b0;
    if (start_cond) begin
      next_state = sesp_pkg::SESP_DEV_ADDR;
      next_cnt = '0;
      next_oe = 1'b0;
    end else if (stop_cond) begin
      next_state = sesp_pkg::SESP_IDLE;
      next_oe = 1'b0;
      if (pending && !busy) begin
        commit_go = 1'b1;
        next_pending = 1'b0;
      end
    end else if (scl_rise) begin
      unique case (state)
        sesp_pkg::SESP_DEV_ADDR, sesp_pkg::SESP_ADDR_HI, sesp_pkg::SESP_ADDR_LO, sesp_pkg::SESP_WR_DATA: begin
          next_sh = {sh[6:0], filt[1]}; // R02
          next_cnt = cnt + 4'h1;
        end
        sesp_pkg::SESP_RD_DATA: next_cnt = cnt + 4'h1;
        sesp_pkg::SESP_RD_ACK: begin
          if (!filt[1]) begin
            next_state = sesp_pkg::SESP_RD_DATA;
            next_cnt = '0;
            next_addr = addr + 13'h0001;
          end else begin
            next_state = sesp_pkg::SESP_IDLE;
          end
        end
        sesp_pkg::SESP_IDLE, sesp_pkg::SESP_ACK_DEV, sesp_pkg::SESP_ACK_HI, sesp_pkg::SESP_ACK_LO,
        sesp_pkg::SESP_ACK_WR: begin
        end
      endcase
    end else if (scl_fall) begin
      // Every change of the driven data waits for a falling clock edge
      unique case (state)
        sesp_pkg::SESP_DEV_ADDR: begin
          if (cnt == sesp_pkg::BITS_PER_BYTE) begin
            next_state = dev_match ? sesp_pkg::SESP_ACK_DEV : sesp_pkg::SESP_IDLE; // R04 R16
            next_oe = dev_match; // R02
          end
        end
        sesp_pkg::SESP_ADDR_HI: begin
          if (cnt == sesp_pkg::BITS_PER_BYTE) begin
            next_state = sesp_pkg::SESP_ACK_HI;
            next_oe = 1'b1;
            next_addr[12:8] = sh[4:0];
          end
        end
        sesp_pkg::SESP_ADDR_LO: begin
          if (cnt == sesp_pkg::BITS_PER_BYTE) begin
            next_state = sesp_pkg::SESP_ACK_LO;
            next_oe = 1'b1;
            next_addr[7:0] = sh;
          end
        end
        sesp_pkg::SESP_WR_DATA: begin
          if (cnt == sesp_pkg::BITS_PER_BYTE) begin
            // A full buffer refuses the byte by withholding the acknowledge
            if (!wp_lat && push_ready) begin // R06 R15
              push_valid = 1'b1;
              next_state = sesp_pkg::SESP_ACK_WR;
              next_oe = 1'b1;
              next_pending = 1'b1;
              next_addr[4:0] = addr[4:0] + 5'h01;
            end else begin
              next_state = sesp_pkg::SESP_IDLE; // R15
            end
          end
        end
        sesp_pkg::SESP_ACK_DEV: begin
          next_cnt = '0;
          if (sh[0]) begin
            next_state = sesp_pkg::SESP_RD_DATA;
            next_oe = !rd_byte[7]; // R03
          end else begin
            next_state = sesp_pkg::SESP_ADDR_HI;
            next_oe = 1'b0;
          end
        end
        sesp_pkg::SESP_ACK_HI: begin
          next_cnt = '0;
          next_oe = 1'b0;
          next_state = sesp_pkg::SESP_ADDR_LO;
        end
        sesp_pkg::SESP_ACK_LO: begin
          next_cnt = '0;
          next_oe = 1'b0;
          next_state = sesp_pkg::SESP_WR_DATA;
          next_wp = wp_eff; // R15
          next_page = addr[12:5];
        end
        sesp_pkg::SESP_ACK_WR: begin
          next_cnt = '0;
          next_oe = 1'b0;
          next_state = sesp_pkg::SESP_WR_DATA;
        end
        sesp_pkg::SESP_RD_DATA: begin
          if (cnt < sesp_pkg::BITS_PER_BYTE) begin
            next_oe = !rd_byte[~cnt[2:0]]; // R03
          end else begin
            next_oe = 1'b0;
            next_state = sesp_pkg::SESP_RD_ACK;
          end
        end
        sesp_pkg::SESP_IDLE, sesp_pkg::SESP_RD_ACK: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= sesp_pkg::SESP_IDLE; // R12
      cnt <= '0;
      sh <= '0;
      addr <= '0;
      page_base <= '0;
      oe <= 1'b0;
      wp_lat <= 1'b0;
      pending <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      addr <= next_addr;
      page_base <= next_page;
      oe <= next_oe;
      wp_lat <= next_wp;
      pending <= next_pending;
    end
  end

  sesp_fifo #(
    .WIDTH(sesp_pkg::WBYTE_W),
    .DEPTH(sesp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_data),
    .out_valid_out(pop_valid),
    .out_ready_in(!busy),
    .out_data_out(pop_data)
  );

  // ============================================================
  // Page commit and ready timer
  assign idx = tmr[sesp_pkg::PAGE_W-1:0];
  assign mem_we = busy && (tmr < sesp_pkg::TMR_W'(sesp_pkg::PAGE_BYTES)) && page_vld[idx];

  always_comb begin
    next_busy = busy;
    next_tmr = tmr;
    next_page_vld = page_vld;
    next_pu_cnt = pu_cnt;
    next_ready = ready;
    if (!ready) begin
      next_pu_cnt = pu_cnt + 1'b1;
      next_ready = (pu_cnt == sesp_pkg::TMR_W'(PU_CYCLES - 1)); // R11
    end
    if (commit_go) begin
      next_busy = 1'b1;
      next_tmr = '0;
    end else if (busy) begin
      next_tmr = tmr + 1'b1;
      if (tmr == sesp_pkg::TMR_W'(WR_CYCLES - 1)) begin
        next_busy = 1'b0; // R17
        next_page_vld = '0;
      end
    end else if (pop_valid) begin
      next_page_vld[pop_data.offset] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy <= 1'b0;
      tmr <= '0;
      page_vld <= '0;
      pu_cnt <= '0;
      ready <= 1'b0; // R12
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
      ready_out <= 1'b0;
      write_busy_out <= 1'b0;
    end else begin
      busy <= next_busy;
      tmr <= next_tmr;
      page_vld <= next_page_vld;
      pu_cnt <= next_pu_cnt;
      ready <= next_ready;
      sda_out <= 1'b0; // R03
      sda_oe_out <= oe && !busy; // R16
      ready_out <= ready;
      write_busy_out <= busy;
    end
  end

  // Arrays carry no reset; an unwritten location reads undefined
  always_ff @(posedge sys_clk_in) begin
    if (pop_valid && !busy) begin
      page_buf[pop_data.offset] <= pop_data.data;
    end
    if (mem_we) begin
      mem[{page_base, idx}] <= page_buf[idx];
    end
  end
endmodule : sesp_port

`default_nettype wire

// [bench/sesp_master.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bus master model: 800 ns bit time, line released reads as pulled up
module sesp_master (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Within a bit, data moves only while the clock is low; the long low phase gives the slave time to answer
  // The slave answers about six samples after a fall, so the clock stays low 600 ns and its answer
  // settles before the rise; a high phase of 200 ns still spans two samples
  task automatic bus_bit(input logic b, output logic r);
    #100 sda_low_out = !b;
    #500 scl_out = 1'b1;
    #150 r = sda_in;
    #50 scl_out = 1'b0;
  endtask : bus_bit
  task automatic bus_byte(input logic [7:0] d, output logic ack, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(d[i], r);
      q[i] = r;
    end
    bus_bit(1'b1, r);
    ack = !r;
  endtask : bus_byte
  task automatic bus_start();
    #100 sda_low_out = 1'b0;
    #600 scl_out = 1'b1;
    #300 sda_low_out = 1'b1;
    #300 scl_out = 1'b0;
  endtask : bus_start
  task automatic bus_stop();
    #100 sda_low_out = 1'b1;
    #600 scl_out = 1'b1;
    #300 sda_low_out = 1'b0;
    #800;
  endtask : bus_stop
  // One-sample pulses on both lines
  task automatic pulse();
    scl_out = 1'b0;
    #100 scl_out = 1'b1;
    #100 sda_low_out = 1'b1;
    #100 sda_low_out = 1'b0;
    #500;
  endtask : pulse
endmodule : sesp_master
`default_nettype wire

// [bench/sesp_port_sva.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checker
module sesp_port_sva #(
  parameter int WR_CYCLES = 200,
  parameter int PU_CYCLES = 20
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic addr_strap_bit0_in,
  input wire logic addr_strap_bit1_in,
  input wire logic addr_strap_bit2_in,
  input wire logic write_inhibit_in,
  input wire logic strapless_pkg_in,
  input wire logic ready_out,
  input wire logic write_busy_out
);
  int rst_cnt, busy_cnt, fall_cnt;
  int next_rst_cnt, next_busy_cnt, next_fall_cnt;
  logic scl_q, next_scl_q;
  // rst_cnt and fall_cnt saturate so long runs never wrap; busy_cnt clears whenever busy is low
  always_comb begin
    next_rst_cnt = (rst_cnt < 1000000) ? rst_cnt + 1 : rst_cnt;
    next_busy_cnt = write_busy_out ? busy_cnt + 1 : 0;
    next_fall_cnt = (scl_q && !scl_in) ? 1 : ((fall_cnt < 99) ? fall_cnt + 1 : 99);
    next_scl_q = scl_in;
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_cnt <= 0;
      busy_cnt <= 0;
      fall_cnt <= 99;
      scl_q <= 1'b1;
    end else begin
      rst_cnt <= next_rst_cnt;
      busy_cnt <= next_busy_cnt;
      fall_cnt <= next_fall_cnt;
      scl_q <= next_scl_q;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  property p_fall; $changed(sda_oe_out) |-> fall_cnt inside {[4:8]}; endproperty
  a_fall: assert property (p_fall) else $error("data changed away from clock fall");
  property p_unready; !ready_out |-> !sda_oe_out; endproperty
  a_unready: assert property (p_unready) else $error("answered before ready");
  property p_busy; write_busy_out |-> !sda_oe_out; endproperty
  a_busy: assert property (p_busy) else $error("answered while busy");
  property p_early; rst_cnt < PU_CYCLES |-> !ready_out; endproperty
  a_early: assert property (p_early) else $error("ready too early");
  property p_late; rst_cnt > PU_CYCLES + 2 |-> ready_out; endproperty
  a_late: assert property (p_late) else $error("ready too late");
  property p_len; $fell(write_busy_out) |-> busy_cnt == WR_CYCLES; endproperty
  a_len: assert property (p_len) else $error("write cycle length wrong");
  property p_max; busy_cnt <= WR_CYCLES; endproperty
  a_max: assert property (p_max) else $error("write cycle overran");
  property p_cause;
    $rose(write_busy_out) |-> scl_in && sda_in && (strapless_pkg_in || !write_inhibit_in);
  endproperty
  a_cause: assert property (p_cause) else $error("write cycle without cause");
  c_ready: cover property ($rose(ready_out));
  c_ack: cover property ($rose(sda_oe_out));
  c_busy: cover property ($fell(write_busy_out));
endmodule : sesp_port_sva
bind sesp_port sesp_port_sva #(.WR_CYCLES(WR_CYCLES), .PU_CYCLES(PU_CYCLES)) sesp_port_sva_i (
  .sys_clk_in, .arst_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .addr_strap_bit0_in,
  .addr_strap_bit1_in, .addr_strap_bit2_in, .write_inhibit_in, .strapless_pkg_in, .ready_out, .write_busy_out);
`default_nettype wire

// [bench/sesp_port_bench.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bench
module sesp_port_bench;
  localparam int PU = 20;
  localparam int WR = 200;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [2:0] strap = 3'h0;
  logic inhibit = 1'b0;
  logic strapless = 1'b0;
  logic ack;
  logic [7:0] q;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  wire logic scl;
  wire logic low;
  wire logic oe;
  wire logic dout;
  wire logic ready;
  wire logic busy;
  // Open-drain wire with pull-up
  wire logic sda = !((oe && !dout) || low);
  sesp_port #(.WR_CYCLES(WR), .PU_CYCLES(PU)) sesp_port_i (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_out(dout), .sda_oe_out(oe), .addr_strap_bit0_in(strap[0]), .addr_strap_bit1_in(strap[1]),
    .addr_strap_bit2_in(strap[2]), .write_inhibit_in(inhibit), .strapless_pkg_in(strapless),
    .ready_out(ready), .write_busy_out(busy));
  sesp_master sesp_master_i (.sda_in(sda), .scl_out(scl), .sda_low_out(low));
  initial forever #50 sys_clk_in = ~sys_clk_in;
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", n, exp, seen);
      fail_count++;
    end
  endtask : check
  // Reset is entered just after an edge; outputs are judged once three clocks have passed under it
  task automatic do_reset();
    @(posedge sys_clk_in);
    #1 arst_n_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1 check("quiet", {5'h00, oe, ready, busy}, 8'h00);
    arst_n_in = 1'b1;
    repeat (PU - 1) @(posedge sys_clk_in);
    #1 check("ready", {7'h00, ready}, 8'h00);
    repeat (4) @(posedge sys_clk_in);
    #1 check("ready", {7'h00, ready}, 8'h01);
  endtask : do_reset
  task automatic probe(input logic [7:0] a, input logic exp);
    sesp_master_i.bus_start();
    sesp_master_i.bus_byte(a, ack, q);
    sesp_master_i.bus_stop();
    check("addr ack", {7'h00, ack}, {7'h00, exp});
  endtask : probe
  task automatic t_match();
    for (int k = 0; k < 8; k++) begin
      strap = k[2:0];
      probe({4'ha, k[2:0], 1'b0}, 1'b1);
      probe({4'ha, ~k[2:0], 1'b0}, 1'b0);
    end
    probe(8'hbe, 1'b0);
    strapless = 1'b1;
    probe(8'ha0, 1'b1);
    probe(8'hae, 1'b0);
    strapless = 1'b0;
    strap = 3'h0;
  endtask : t_match
  // Byte write to one fixed location; the strobe of the inhibit decides the data ack unless the package is strapless
  task automatic xfer(input logic [7:0] d, input logic exp);
    sesp_master_i.bus_start();
    sesp_master_i.bus_byte(8'ha0, ack, q);
    check("dev ack", {7'h00, ack}, 8'h01);
    sesp_master_i.bus_byte(8'h01, ack, q);
    sesp_master_i.bus_byte(8'h23, ack, q);
    sesp_master_i.bus_byte(d, ack, q);
    check("data ack", {7'h00, ack}, {7'h00, exp});
    sesp_master_i.bus_stop();
    check("busy", {7'h00, busy}, {7'h00, exp});
  endtask : xfer
  task automatic readback(input logic [7:0] exp);
    for (int i = 0; i < 3 * WR && busy !== 1'b0; i++) begin
      @(posedge sys_clk_in);
      #1;
    end
    check("busy end", {7'h00, busy}, 8'h00);
    sesp_master_i.bus_start();
    sesp_master_i.bus_byte(8'ha0, ack, q);
    sesp_master_i.bus_byte(8'h01, ack, q);
    sesp_master_i.bus_byte(8'h23, ack, q);
    sesp_master_i.bus_start();
    sesp_master_i.bus_byte(8'ha1, ack, q);
    sesp_master_i.bus_byte(8'hff, ack, q);
    sesp_master_i.bus_stop();
    check("read data", q, exp);
  endtask : readback
  task automatic t_write();
    inhibit = 1'b1;
    xfer(8'h5a, 1'b0);
    inhibit = 1'b0;
    xfer(8'h5a, 1'b1);
    probe(8'ha0, 1'b0);
    readback(8'h5a);
    strapless = 1'b1;
    inhibit = 1'b1;
    xfer(8'hc3, 1'b1);
    readback(8'hc3);
    strapless = 1'b0;
    inhibit = 1'b0;
  endtask : t_write
  // A start made of one-sample pulses must not open a transfer
  task automatic t_glitch();
    sesp_master_i.pulse();
    sesp_master_i.bus_byte(8'ha0, ack, q);
    sesp_master_i.bus_stop();
    check("glitch ack", {7'h00, ack}, 8'h00);
  endtask : t_glitch
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    do_reset();
    t_match();
    t_write();
    t_glitch();
    do_reset();
    probe(8'ha0, 1'b1);
    summarize();
  end
endmodule : sesp_port_bench
`default_nettype wire
